//--- host_sequencer.sv
// host command interpreter of the multi-channel serial link engine
// assumes host port and link logic on core_clk; link answers each request once
`timescale 1ns/1ps
`include "link_engine_params.svh"
module host_sequencer import link_engine_pkg::*; #(
  parameter int NCH              = 8,
  parameter int FIFO_DEPTH       = 8,
  parameter int XFER_TIMEOUT_CYC = `XFER_LIMIT_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           nrst,
  // host register port
  input  wire logic           host_wr,
  input  wire logic           host_rd,
  input  wire logic [5:0]     host_addr,
  input  wire logic [31:0]    host_wdata,
  output logic      [31:0]    host_rdata,
  output logic                host_rvalid,
  // link requests
  output logic                link_req_valid,
  input  wire logic           link_req_ready,
  output logic      [1:0]     link_req_op,
  output logic      [2:0]     link_req_ch,
  output logic      [31:0]    link_req_cs,
  output logic      [31:0]    link_req_d0,
  output logic      [31:0]    link_req_d1,
  // link answers
  input  wire logic           link_rsp_valid,
  output logic                link_rsp_ready,
  input  wire logic           link_rsp_fail,
  input  wire logic [31:0]    link_rsp_d0,
  input  wire logic [31:0]    link_rsp_d1,
  input  wire logic [15:0]    link_rsp_ptr,
  input  wire logic [7:0]     link_rsp_unit,
  // channel control
  output logic                link_halt,
  output logic      [NCH-1:0] chan_active
);
  localparam int TMO_LIM = XFER_TIMEOUT_CYC - `XFER_MARGIN_CYC;

  // ==========================================
  // decoding
  function automatic logic [32:0] read_keep(input logic setup, input logic [7:0] opc);
    logic [32:0] k;
    k = 33'h0_0000_0000;
    if (!setup)
      k = {1'b1, 32'hffff_ffff};
    else if (opc[7:2] == `OPC_READ_GROUP)
    begin
      unique case (opc[1:0])
        2'h0: k = {1'b0, `READ_BYTE_MASK};
        2'h1: k = {1'b0, `READ_WORD_MASK};
        2'h2: k = {1'b0, 32'hffff_ffff};
        2'h3: k = {1'b1, 32'hffff_ffff};
      endcase
    end
    return k;
  endfunction

  state_t      state_reg;
  op_t         op_reg;
  logic [31:0] cmd_reg, data_reg, cs_cap_reg, d0_cap_reg, d1_cap_reg;
  logic [31:0] rsp_d0_reg, rsp_d1_reg;
  logic [15:0] rsp_ptr_reg;
  logic [7:0]  mask_reg;
  logic [2:0]  ch_reg, rsp_ch_reg;
  logic [1:0]  fk_reg;
  logic        wk_reg, fwait_reg, rsp_fail_reg, setup_reg, halt_reg, rsp_ready_reg;
  logic [NCH-1:0] pend_reg, fail_reg, run_reg, seen_reg;
  logic [7:0]  unit_reg [NCH];
  logic [31:0] tmo_reg;
  logic [31:0] rdata_reg;
  logic        rvalid_reg;
  logic [1:0]  rd_kind_reg;
  logic [2:0]  rd_ch_reg;
  logic [31:0] mem_rdata;
  logic        rd_pend_reg, rd_hit_reg;
  logic [2:0]  rsp_ch_in;
  logic [7:0]  rsp_unit_reg;

  wire host_mem_rd = host_rd & host_addr[5];
  wire host_mem_wr = host_wr & host_addr[5];
  wire cmd_wr      = host_wr & (host_addr == `HOST_ADDR_CMD) & ~host_wdata[`CMD_IGNORE_BIT];
  wire w_stop      = host_wdata[15:0] == `CMD_STOP_CODE;
  wire w_transfer_trigger_command      = host_wdata[15:8] == `CMD_TRANSFER_TRIGGER_COMMAND_CODE;
  wire w_setup     = host_wdata[15:8] == `CMD_SETUP_CODE;
  wire w_norm      = host_wdata[15:8] == `CMD_NORMAL_CODE;
  // a busy command register only takes a halt; other writes are dropped
  wire accept_halt = cmd_wr & w_stop;
  wire accept_new  = cmd_wr & ~w_stop & (state_reg == S_IDLE);
  wire ch_sel      = mask_reg[ch_reg];
  wire last_ch     = ch_reg == 3'(NCH - 1);
  wire seq_rd      = (state_reg == S_FETCH) & ~fwait_reg & ~host_mem_rd;
  wire [32:0] keep = read_keep(setup_reg, cs_cap_reg[31:24]);
  wire is_start    = op_reg != OP_TRIGGER;

  // response write-back: start fills if2, trigger fills if0/if1 by size
  wire        seq_need = is_start ? ~wk_reg : (~rsp_fail_reg & (wk_reg ? keep[32] : 1'b1));
  wire        seq_we   = (state_reg == S_RSPW) & seq_need & ~host_mem_wr;
  wire [1:0]  seq_slot = is_start ? `SLOT_IF2 : (wk_reg ? `SLOT_IF1 : `SLOT_IF0);
  wire [31:0] seq_wd   = is_start ? {16'h0000, rsp_ptr_reg}
                                  : (wk_reg ? rsp_d1_reg : (rsp_d0_reg & keep[31:0]));
  wire        rsp_take = link_rsp_valid & ~rsp_ready_reg;

  // ==========================================
  // request queue and interface store
  req_stream_if #(.W($bits(req_t))) push_s ();
  req_t head;
  assign push_s.valid = state_reg == S_PUSH;
  assign push_s.data  = {op_reg, ch_reg, cs_cap_reg, d0_cap_reg, d1_cap_reg};

  req_fifo #(.W($bits(req_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .flush     (halt_reg),
    .in_s      (push_s),
    .out_valid (link_req_valid),
    .out_ready (link_req_ready),
    .out_data  (head)
  );
  assign link_req_op = head.op;
  assign link_req_ch = head.ch;
  assign link_req_cs = head.cs;
  assign link_req_d0 = head.d0;
  assign link_req_d1 = head.d1;

  // host has priority on both ports; the sequencer waits a cycle
  iface_regs_mem #(.DW(32), .AW(5)) u_mem (
    .core_clk (core_clk),
    .we       (host_mem_wr | seq_we),
    .waddr    (host_mem_wr ? host_addr[4:0] : {rsp_ch_reg, seq_slot}),
    .wdata    (host_mem_wr ? host_wdata : seq_wd),
    .raddr    (host_mem_rd ? host_addr[4:0] : {ch_reg, fk_reg}),
    .rdata    (mem_rdata)
  );

  // ==========================================
  // command sequencer
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_reg <= S_IDLE; op_reg <= OP_NONE; cmd_reg <= 32'h0000_0000;
      data_reg <= 32'h0000_0000; mask_reg <= 8'h00; ch_reg <= 3'h0; fk_reg <= 2'h0;
      wk_reg <= 1'b0; fwait_reg <= 1'b0; setup_reg <= 1'b0; halt_reg <= 1'b0;
      pend_reg <= '0; fail_reg <= '0; run_reg <= '0; seen_reg <= '0; tmo_reg <= 32'h0;
      rsp_ready_reg <= 1'b0; rsp_fail_reg <= 1'b0; rsp_ch_reg <= 3'h0;
      unit_reg <= '{default: 8'h00};
    end
    else
    begin
      halt_reg      <= 1'b0;
      rsp_ready_reg <= 1'b0;
      tmo_reg       <= (state_reg == S_IDLE) ? 32'h0 : tmo_reg + 32'h1;
      if (accept_halt)
      begin
        cmd_reg   <= host_wdata;
        state_reg <= S_HALT;
      end
      else
      begin
        unique case (state_reg)
          S_IDLE:
          begin
            // stray answers after a timeout or halt are drained and dropped
            rsp_ready_reg <= rsp_take;
            if (accept_new)
            begin
              cmd_reg  <= host_wdata;
              mask_reg <= host_wdata[7:0];
              ch_reg   <= 3'h0;
              pend_reg <= '0;
              fail_reg <= '0;
              op_reg   <= w_transfer_trigger_command ? OP_TRIGGER : w_setup ? OP_SETUP_START
                        : w_norm ? OP_NORMAL_START : OP_NONE;
              if (w_setup | w_norm)
              begin
                setup_reg <= w_setup;
                seen_reg  <= seen_reg & ~host_wdata[NCH-1:0];
                run_reg   <= run_reg & ~host_wdata[NCH-1:0];
              end
              state_reg <= (w_transfer_trigger_command | w_setup | w_norm) ? S_SCAN : S_DONE;
              if (!(w_transfer_trigger_command | w_setup | w_norm))
                fail_reg <= '1;
            end
          end
          S_SCAN:
          begin
            if (ch_sel && (op_reg != OP_TRIGGER || run_reg[ch_reg]))
            begin
              fk_reg    <= `SLOT_CS;
              state_reg <= S_FETCH;
            end
            else
            begin
              if (ch_sel)
                fail_reg[ch_reg] <= 1'b1;
              ch_reg    <= last_ch ? ch_reg : ch_reg + 3'h1;
              state_reg <= last_ch ? S_WAIT : S_SCAN;
            end
          end
          S_FETCH:
          begin
            if (fwait_reg)
            begin
              fwait_reg <= 1'b0;
              unique case (fk_reg)
                `SLOT_CS:  cs_cap_reg <= mem_rdata;
                `SLOT_IF0: d0_cap_reg <= mem_rdata;
                default:   d1_cap_reg <= mem_rdata;
              endcase
              fk_reg    <= fk_reg + 2'h1;
              state_reg <= (fk_reg == `SLOT_IF1) ? S_PUSH : S_FETCH;
            end
            else if (seq_rd)
              fwait_reg <= 1'b1;
          end
          S_PUSH:
          begin
            if (push_s.ready)
            begin
              pend_reg[ch_reg] <= 1'b1;
              if (op_reg == OP_TRIGGER)
                seen_reg[ch_reg] <= 1'b1;
              ch_reg    <= last_ch ? ch_reg : ch_reg + 3'h1;
              state_reg <= last_ch ? S_WAIT : S_SCAN;
            end
          end
          S_WAIT:
          begin
            if (pend_reg == '0)
              state_reg <= S_DONE;
            else if (op_reg == OP_TRIGGER && tmo_reg >= 32'(TMO_LIM))
            begin
              fail_reg  <= fail_reg | pend_reg;
              pend_reg  <= '0;
              state_reg <= S_DONE;
            end
            else if (rsp_take)
            begin
              rsp_ready_reg <= 1'b1;
              rsp_ch_reg    <= rsp_ch_in;
              rsp_fail_reg  <= link_rsp_fail;
              rsp_d0_reg    <= link_rsp_d0;
              rsp_d1_reg    <= link_rsp_d1;
              rsp_ptr_reg   <= link_rsp_ptr;
              wk_reg        <= 1'b0;
              state_reg     <= S_RSPW;
            end
          end
          S_RSPW:
          begin
            if (seq_we || !seq_need)
            begin
              if (wk_reg || is_start)
              begin
                pend_reg[rsp_ch_reg] <= 1'b0;
                fail_reg[rsp_ch_reg] <= fail_reg[rsp_ch_reg] | rsp_fail_reg;
                if (is_start)
                  unit_reg[rsp_ch_reg] <= rsp_unit_reg;
                state_reg <= S_WAIT;
              end
              wk_reg <= 1'b1;
            end
          end
          S_DONE:
          begin
            cmd_reg   <= 32'h0000_0000;
            data_reg  <= {{(32-NCH){1'b0}}, fail_reg};
            if (is_start && op_reg != OP_NONE)
              run_reg <= run_reg | (mask_reg[NCH-1:0] & ~fail_reg);
            state_reg <= S_IDLE;
          end
          S_HALT:
          begin
            halt_reg  <= 1'b1;
            // a halt in mid-fetch must not leave a stale capture pending
            fwait_reg <= 1'b0;
            run_reg   <= '0;
            pend_reg  <= '0;
            setup_reg <= 1'b0;
            cmd_reg   <= 32'h0000_0000;
            data_reg  <= 32'h0000_0000;
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // in-order link: the answer belongs to the lowest pending channel
  always_comb
  begin
    rsp_ch_in = 3'h0;
    for (int i = NCH - 1; i >= 0; i--)
      if (pend_reg[i])
        rsp_ch_in = 3'(i);
  end
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      rsp_unit_reg <= 8'h00;
    else if (rsp_take && state_reg == S_WAIT)
      rsp_unit_reg <= link_rsp_unit;
  end

  // ==========================================
  // host read path: two cycles from host_rd to host_rvalid
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      rd_kind_reg <= 2'h0; rd_ch_reg <= 3'h0; rvalid_reg <= 1'b0; rdata_reg <= 32'h0;
      rd_pend_reg <= 1'b0; rd_hit_reg <= 1'b0;
    end
    else
    begin
      rd_kind_reg <= host_mem_rd ? 2'h3 : (host_addr == `HOST_ADDR_CMD) ? 2'h0
                   : (host_addr == `HOST_ADDR_DATA) ? 2'h1 : 2'h2;
      rd_hit_reg  <= host_mem_rd | (host_addr == `HOST_ADDR_CMD)
                   | (host_addr == `HOST_ADDR_DATA) | (host_addr[5:3] == 3'h1);
      rd_ch_reg   <= host_addr[2:0];
      rd_pend_reg <= host_rd;
      // valid rises together with the data it marks
      rvalid_reg  <= rd_pend_reg;
      if (rd_pend_reg)
      begin
        if (!rd_hit_reg)
          rdata_reg <= 32'h0000_0000;
        else
        begin
          unique case (rd_kind_reg)
            2'h0: rdata_reg <= cmd_reg;
            2'h1: rdata_reg <= data_reg;
            // unit number hides once a trigger has gone out on that channel
            2'h2: rdata_reg <= seen_reg[rd_ch_reg] ? 32'h0 : {24'h0, unit_reg[rd_ch_reg]};
            2'h3: rdata_reg <= mem_rdata;
          endcase
        end
      end
    end
  end
  assign host_rdata     = rdata_reg;
  assign host_rvalid    = rvalid_reg;
  assign link_rsp_ready = rsp_ready_reg;
  assign link_halt      = halt_reg;
  assign chan_active    = run_reg;

  // ==========================================
  // checks
  chk_done_clears_cmd: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg == S_DONE && !accept_halt |=> cmd_reg == 32'h0 && state_reg == S_IDLE)
    else $error("command not cleared on completion");
  chk_busy_write_drop: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg inside {S_SCAN, S_FETCH, S_PUSH, S_WAIT, S_RSPW} && cmd_wr && !w_stop
    |=> $stable(cmd_reg))
    else $error("busy command register was overwritten");
  chk_push_in_mask: assert property (@(posedge core_clk) disable iff (!nrst)
    push_s.valid && push_s.ready |-> mask_reg[ch_reg])
    else $error("request sent on unselected channel");
  chk_trigger_bound: assert property (@(posedge core_clk) disable iff (!nrst)
    op_reg == OP_TRIGGER && state_reg != S_IDLE |-> tmo_reg < 32'(XFER_TIMEOUT_CYC))
    else $error("trigger exceeded its time limit");
  chk_halt_idles: assert property (@(posedge core_clk) disable iff (!nrst)
    accept_halt |=> ##1 run_reg == '0 && cmd_reg == 32'h0 && link_halt)
    else $error("halt left a channel running");
  chk_unit_hidden: assert property (@(posedge core_clk) disable iff (!nrst)
    host_rd && host_addr[5:3] == 3'h1 && seen_reg[host_addr[2:0]] && !accept_new
    |=> ##1 host_rdata == 32'h0)
    else $error("unit number visible after trigger");
  chk_word_read_low: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_we && !is_start && !wk_reg && setup_reg && cs_cap_reg[31:24] == 8'h45
    |-> seq_wd[31:16] == 16'h0)
    else $error("word read spilled above low half");
  chk_ptr_to_if2: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_we && is_start |-> seq_slot == `SLOT_IF2 && seq_wd[15:0] == rsp_ptr_reg)
    else $error("pointer not written to interface 2");
endmodule

//--- iface_regs_mem.sv
// per-channel control/status and interface word store, registered read
// assumes one writer and one reader per cycle, arbitrated outside
`timescale 1ns/1ps
module iface_regs_mem #(
  parameter int DW = 32,
  parameter int AW = 5
) (
  input  wire logic          core_clk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] store_reg [2**AW];

  always_ff @(posedge core_clk)
  begin
    if (we)
      store_reg[waddr] <= wdata;
    rdata <= store_reg[raddr];
  end
endmodule

//--- link_engine_params.svh
// constants of the host command sequencer: host port map, command codes, timing
// assumes a 100 MHz core clock and a compiler that honours include guards
`ifndef LINK_ENGINE_PARAMS_SVH
`define LINK_ENGINE_PARAMS_SVH

// ==========================================
// host port map
`define HOST_ADDR_CMD   6'h00
`define HOST_ADDR_DATA  6'h01
`define HOST_UNIT_BASE  6'h08
`define SLOT_CS         2'h0
`define SLOT_IF0        2'h1
`define SLOT_IF1        2'h2
`define SLOT_IF2        2'h3

// ==========================================
// command codes
`define CMD_IGNORE_BIT  31
`define CMD_STOP_CODE   16'h0800
`define CMD_TRANSFER_TRIGGER_COMMAND_CODE   8'h10
`define CMD_SETUP_CODE  8'h0f
`define CMD_NORMAL_CODE 8'h09
`define OPC_READ_GROUP  6'h11
`define READ_BYTE_MASK  32'h0000_00ff
`define READ_WORD_MASK  32'h0000_ffff

// ==========================================
// timing
`define CLK_PERIOD_NS   10
`define XFER_LIMIT_NS   100000
`define XFER_MARGIN_CYC 4

`endif

//--- link_engine_pkg.sv
// types shared by the host command sequencer and its request queue
// assumes an eight-channel engine; channel index fits three bits
package link_engine_pkg;

  typedef enum logic [1:0] {OP_SETUP_START, OP_NORMAL_START, OP_TRIGGER, OP_NONE} op_t;

  typedef enum logic [2:0] {S_IDLE, S_SCAN, S_FETCH, S_PUSH, S_WAIT, S_RSPW, S_DONE, S_HALT}
    state_t;

  typedef struct packed {
    op_t         op;
    logic [2:0]  ch;
    logic [31:0] cs;
    logic [31:0] d0;
    logic [31:0] d1;
  } req_t;

endpackage

//--- link_partner.sv
// far side of the serial link: answers each request once, in order, except those still queued when a halt clears the queue
// assumes requests and answers on core_clk; delay and failures set by bench
`timescale 1ns/1ps
module link_partner import link_engine_pkg::*; (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // bench controls
  input  wire logic [7:0]  fail_mask,
  input  wire logic [7:0]  delay,
  input  wire logic        halt,
  // requests
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [1:0]  req_op,
  input  wire logic [2:0]  req_ch,
  input  wire logic [31:0] req_cs,
  input  wire logic [31:0] req_d0,
  input  wire logic [31:0] req_d1,
  // answers
  output logic             rsp_valid,
  input  wire logic        rsp_ready,
  output logic             rsp_fail,
  output logic [31:0]      rsp_d0,
  output logic [31:0]      rsp_d1,
  output logic [15:0]      rsp_ptr,
  output logic [7:0]       rsp_unit
);
  req_t q[$];
  req_t r;
  int   w;
  // ==========
  // answer engine
  // a slow far side also stalls the queue every other cycle
  always @(posedge core_clk)
  begin
    if (!nrst || halt)
    begin
      q.delete();
      w = 0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      {rsp_fail, rsp_d0, rsp_d1, rsp_ptr, rsp_unit} <= '0;
    end
    else
    begin
      req_ready <= (delay == 8'h00) || !req_ready;
      if (req_valid && req_ready)
        q.push_back({req_op, req_ch, req_cs, req_d0, req_d1});
      if (rsp_valid && rsp_ready)
      begin
        rsp_valid <= 1'b0;
        // released lines carry junk so a stale answer is never reused
        rsp_d0    <= ~rsp_d0;
        rsp_d1    <= ~rsp_d1;
      end
      else if (!rsp_valid && q.size() > 0)
      begin
        if (w < delay)
          w++;
        else
        begin
          r = q.pop_front();
          w = 0;
          rsp_valid <= 1'b1;
          rsp_fail  <= fail_mask[r.ch];
          rsp_d0    <= {r.d0[15:0], r.d0[31:16]} ^ r.cs;
          rsp_d1    <= ~r.d1;
          rsp_ptr   <= {8'h12, 5'h00, r.ch};
          rsp_unit  <= {5'h08, r.ch};
        end
      end
    end
  end
endmodule

//--- req_fifo.sv
// request queue toward the serial link: compacting shift register
// assumes the link side drains with out_ready; head entry is a flop
`timescale 1ns/1ps
module req_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         flush,
  // fill side
  req_stream_if.snk         in_s,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] data_reg [DEPTH];
  logic         vld_reg  [DEPTH];
  logic [W-1:0] shd      [DEPTH+1];
  logic         shv      [DEPTH+1];
  wire          pop  = vld_reg[0] & out_ready;
  // compaction keeps the last slot free until truly full
  wire          push = in_s.valid & ~vld_reg[DEPTH-1];

  assign in_s.ready = ~vld_reg[DEPTH-1];
  assign out_valid  = vld_reg[0];
  assign out_data   = data_reg[0];
  assign shd[DEPTH] = '0;
  assign shv[DEPTH] = 1'b0;

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_slot
    // slot zero has no neighbour below; the clamp keeps the index in range
    localparam int PREV = (i == 0) ? 0 : i - 1;
    wire sv   = pop ? shv[i+1] : vld_reg[i];
    wire take = push & ~sv & ((i == 0) ? 1'b1 : (pop ? vld_reg[i] : vld_reg[PREV]));
    assign shd[i] = data_reg[i];
    assign shv[i] = vld_reg[i];
    always_ff @(posedge core_clk)
    begin
      if (!nrst || flush)
      begin
        vld_reg[i]  <= 1'b0;
        data_reg[i] <= '0;
      end
      else
      begin
        vld_reg[i]  <= sv | take;
        data_reg[i] <= take ? in_s.data : (pop ? shd[i+1] : data_reg[i]);
      end
    end
  end
endmodule

//--- req_stream_if.sv
// valid/ready carrier from the sequencer into the request queue
// assumes both ends on core_clk
`timescale 1ns/1ps
interface req_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- serial_link_host_sequencer_tb.sv
// self-checking bench of the host command sequencer
// assumes link_partner on the far side and a shortened transfer timeout
`timescale 1ns/1ps
module serial_link_host_sequencer_tb;
  localparam int TO = 200;
  logic        core_clk, nrst, host_wr, host_rd, host_rvalid;
  logic [5:0]  host_addr;
  logic [31:0] host_wdata, host_rdata;
  logic        lv, lr, sv, sr, sf, link_halt;
  logic [1:0]  lop;
  logic [2:0]  lch;
  logic [31:0] lcs, ld0, ld1, sd0, sd1;
  logic [15:0] sptr;
  logic [7:0]  sunit, chan_active, fmask, dly;
  logic [31:0] seed, dr, v, a0, a1, cs, p;
  int          err_count, checks_done, cyc, k;

  host_sequencer #(.XFER_TIMEOUT_CYC(TO)) dut (.core_clk(core_clk), .nrst(nrst),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .link_req_valid(lv),
    .link_req_ready(lr), .link_req_op(lop), .link_req_ch(lch), .link_req_cs(lcs),
    .link_req_d0(ld0), .link_req_d1(ld1), .link_rsp_valid(sv), .link_rsp_ready(sr),
    .link_rsp_fail(sf), .link_rsp_d0(sd0), .link_rsp_d1(sd1), .link_rsp_ptr(sptr),
    .link_rsp_unit(sunit), .link_halt(link_halt), .chan_active(chan_active));

  link_partner far (.core_clk(core_clk), .nrst(nrst), .fail_mask(fmask), .delay(dly),
    .halt(link_halt), .req_valid(lv), .req_ready(lr), .req_op(lop), .req_ch(lch),
    .req_cs(lcs), .req_d0(ld0), .req_d1(ld1), .rsp_valid(sv), .rsp_ready(sr),
    .rsp_fail(sf), .rsp_d0(sd0), .rsp_d1(sd1), .rsp_ptr(sptr), .rsp_unit(sunit));

  // ==========
  // helpers
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      err_count++;
      $display("FAIL %0t got %h want %h", $time, s, e);
    end
  endtask

  task results();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // the extra edge keeps back-to-back writes from retoggling the strobe at once
  task wr(input logic [5:0] a, input logic [31:0] d);
    host_wr    <= 1'b1;
    host_addr  <= a;
    host_wdata <= d;
    @(posedge core_clk);
    host_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task rd(input logic [5:0] a, output logic [31:0] d);
    int n;
    host_rd   <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    host_rd <= 1'b0;
    n = 0;
    while (host_rvalid !== 1'b1 && n < 8)
    begin
      @(posedge core_clk);
      n++;
    end
    d = host_rdata;
    if (n == 8)
      chk(32'h0, 32'h1);
  endtask

  // polls the command word; the bound, 70 polls of three cycles each, outlasts the 200-cycle shortened transfer limit
  task wt(output logic [31:0] d);
    int n;
    n = 0;
    d = 32'h1;
    while (d !== 32'h0 && n < 70)
    begin
      rd(6'h00, d);
      n++;
    end
    chk(d, 32'h0);
    rd(6'h01, d);
  endtask

  task cmd(input logic [31:0] c, output logic [31:0] d);
    wr(6'h00, c);
    wt(d);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      results();
    end
  end

  // ==========
  // scenarios
  initial
  begin
    seed = 32'h0000_c7d9;
    {nrst, host_wr, host_rd, host_addr, host_wdata, fmask} = '0;
    dly = 8'h03;
    {err_count, checks_done, cyc} = '0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd(6'h00, v);
    chk(v, 32'h0);
    cmd(32'h0000_0800, dr);
    chk({24'h0, chan_active}, 32'h0);
    // an unknown code completes at once with every channel marked failed
    cmd(32'h0000_0123, dr);
    chk(dr, 32'h0000_00ff);
    wr(6'h00, 32'h8000_0f01);
    rd(6'h00, v);
    chk(v, 32'h0);
    rd(6'h02, v);
    chk(v, 32'h0);
    fmask <= 8'h02;
    cmd(32'h0000_0f03, dr);
    chk(dr, 32'h2);
    chk({24'h0, chan_active}, 32'h1);
    rd(6'h08, v);
    chk(v, 32'h0000_0040);
    rd(6'h23, v);
    chk(v, 32'h0000_1200);
    p = v;
    fmask <= 8'h00;
    a0 = xs();
    a1 = xs();
    wr(6'h21, a0);
    wr(6'h22, a1);
    for (k = 0; k < 4; k++)
    begin
      // sized reads walk the table from its pointer, as discovery does
      cs = {8'h44 + k[7:0], 8'h00, p[15:0] + 16'(2 * k)};
      wr(6'h20, cs);
      cmd(32'h0000_1001, dr);
      chk(dr, 32'h0);
      v  = {a0[15:0], a0[31:16]} ^ cs;
      a0 = (k == 0) ? (v & 32'hff) : (k == 1) ? (v & 32'hffff) : v;
      rd(6'h21, v);
      chk(v, a0);
    end
    rd(6'h22, v);
    chk(v, ~a1);
    for (k = 0; k < 4; k++)
    begin
      wr(6'h21, xs());
      wr(6'h20, {8'h64 + k[7:0], 8'h00, 16'h2000});
      cmd(32'h0000_1001, dr);
      chk(dr, 32'h0);
    end
    cmd(32'h0000_1005, dr);
    chk(dr, 32'h4);
    rd(6'h08, v);
    chk(v, 32'h0);
    cmd(32'h0000_0800, dr);
    chk({24'h0, chan_active}, 32'h0);
    cmd(32'h0000_0901, dr);
    chk(dr, 32'h0);
    chk({24'h0, chan_active}, 32'h1);
    wr(6'h20, 32'h0);
    for (k = 0; k < 3; k++)
    begin
      rd(6'h21, v);
      rd(6'h22, v);
      a0 = xs();
      a1 = xs();
      wr(6'h21, a0);
      wr(6'h22, a1);
      cmd(32'h0000_1001, dr);
      chk(dr, 32'h0);
      rd(6'h21, v);
      chk(v, {a0[15:0], a0[31:16]});
      rd(6'h22, v);
      chk(v, ~a1);
    end
    // a second trigger while busy must be dropped, else channel 1 would fail
    wr(6'h00, 32'h0000_1001);
    wr(6'h00, 32'h0000_1003);
    wt(dr);
    chk(dr, 32'h0);
    fmask <= 8'h01;
    cmd(32'h0000_1001, dr);
    chk(dr, 32'h1);
    // a halt is taken even while a trigger is still busy
    wr(6'h00, 32'h0000_1001);
    cmd(32'h0000_0800, dr);
    chk({24'h0, chan_active}, 32'h0);
    results();
  end
endmodule
